/* File: core/fsio_map.svh */
`ifndef FSIO_MAP_SVH
`define FSIO_MAP_SVH

// register word offsets (byte addresses)
`define FSIO_REG_CTRL      8'h00
`define FSIO_REG_OUT1      8'h04
`define FSIO_REG_OUT2      8'h08
`define FSIO_REG_FULLSCALE 8'h0C
`define FSIO_REG_TESTFLOW  8'h10
`define FSIO_REG_STATUS    8'h14
`define FSIO_REG_EVENTS    8'h18

// output config fields: [2:0] function, [3] sink, [4] normally closed
`define FSIO_OCFG_FUNC_LSB 0
`define FSIO_OCFG_SINK_BIT 3
`define FSIO_OCFG_NC_BIT   4
`define FSIO_OUT1_RESET    5'h01
`define FSIO_OUT2_RESET    5'h06

// ctrl fields: [2:0] input function, [3] pump mode, [4] test start
`define FSIO_CTRL_PUMP_BIT 3
`define FSIO_CTRL_TEST_BIT 4
`define FSIO_CTRL_RESET    5'h00

// full scale in 0.01 ml/s, test flow in 0.1 ml/s
`define FSIO_FULLSCALE_MAX 20'd800000
`define FSIO_TESTFLOW_MAX  16'd32000

// timing in ns and derived cycles at 50 ns
`define FSIO_CLK_NS        50
`define FSIO_TRIP_NS       100000
`define FSIO_PAUSE_NS      2000000000
`define FSIO_TRIP_CYC      (`FSIO_TRIP_NS / `FSIO_CLK_NS)
`define FSIO_PAUSE_CYC     (`FSIO_PAUSE_NS / `FSIO_CLK_NS)

`endif

/* File: core/fsio_pkg.sv */
package fsio_pkg;

    typedef enum logic [2:0] {
        FSIO_FN_OFF   = 3'h0,
        FSIO_FN_PULSE = 3'h1,
        FSIO_FN_DOSE  = 3'h2,
        FSIO_FN_NEG   = 3'h3,
        FSIO_FN_LOWER = 3'h4,
        FSIO_FN_UPPER = 3'h5,
        FSIO_FN_EMPTY = 3'h6
    } fsio_out_fn_t;

    typedef enum logic [2:0] {
        FSIO_IN_OFF    = 3'h0,
        FSIO_IN_RESET  = 3'h1,
        FSIO_IN_DOSE   = 3'h2,
        FSIO_IN_CREEP  = 3'h3,
        FSIO_IN_OFFSET = 3'h4
    } fsio_in_fn_t;

    // measurement state coming from the meter core
    typedef struct packed {
        logic startup;
        logic empty;
        logic flow;
        logic negative;
        logic below_lower;
        logic above_upper;
        logic pulse;
        logic dosing;
        logic pulsating;
    } fsio_meas_t;

    // one switching output as drive enable plus level
    typedef struct packed {
        logic en;
        logic level;
    } fsio_drive_t;

endpackage

/* File: core/fsio_top.sv */
// Notes on behaviour
// (R1) full scale 0..8000 ml/s, 0.01 steps
// (R2) full scale defaults to pipe maximum flow
// (R3) undervoltage releases every switching output
// (R4) overload: release after 100us, retry 2s
// (R5) one function per switching output
// (R6) reset: pulse and empty pipe, source, open
// (R7) sink/source and open/closed per output
// (R8) empty pipe: open drives when empty
// (R9) pulse: source pulses, sink low idle
// (R10) upper limit: open drives up to limit
// (R11) lower limit: closed drives below limit
// (R12) dosing: released at startup, open while dosing
// (R13) integrator avoids closed sense for dosing
// (R14) control input functions, default off
// (R15) rising edge clears totaliser
// (R16) rising edge captures zero offset
// (R17) level disables creep suppression
// (R18) controller raises input to start dose
// (R19) running dose ignores start requests
// (R20) test flow simulation up to 3200 ml/s
// (R21) restart stops and clears test flow
// (R22) pump mode forces strong filters while pulsation is reported
// (R23) output is drive enable plus polarity
// (R24) control input synchronised, one-cycle edge
`timescale 1ns/1ps
`default_nettype none
`include "fsio_map.svh"

module fsio_top
    import fsio_pkg::*;
#(
    parameter int unsigned TRIP_CYC  = `FSIO_TRIP_CYC,
    parameter int unsigned PAUSE_CYC = `FSIO_PAUSE_CYC,
    parameter logic [19:0] FULLSCALE_DEFAULT = 20'd100000
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // meter core side
    input  wire fsio_meas_t  meas_i,
    input  wire logic        undervolt_i,
    input  wire logic [1:0]  overload_i,
    input  wire logic        control_input_i,
    output fsio_drive_t      first_switch_output_o,
    output fsio_drive_t      second_switch_output_o,
    output logic             counter_clear_o,
    output logic             offset_capture_o,
    output logic             dose_start_o,
    output logic             creep_off_o,
    output logic             filter_strong_o,
    output logic             test_active_o,
    output logic      [15:0] test_flow_o,
    output logic      [19:0] full_scale_o
);

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [4:0]  ctrl;
    logic [4:0]  out_cfg [2];
    logic [19:0] full_scale;
    logic [15:0] test_flow;
    logic [2:0]  events;

    // bus decode
    wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr   = bus_req & wb_we_i;
    wire wr_ctrl  = bus_wr & (wb_adr_i == `FSIO_REG_CTRL);
    wire wr_out1  = bus_wr & (wb_adr_i == `FSIO_REG_OUT1);
    wire wr_out2  = bus_wr & (wb_adr_i == `FSIO_REG_OUT2);
    wire wr_fs    = bus_wr & (wb_adr_i == `FSIO_REG_FULLSCALE);
    wire wr_test  = bus_wr & (wb_adr_i == `FSIO_REG_TESTFLOW);
    wire wr_evt   = bus_wr & (wb_adr_i == `FSIO_REG_EVENTS);
    wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wdata = wb_dat_i & wmask;
    wire fs_ok    = wdata[19:0] <= `FSIO_FULLSCALE_MAX;
    wire test_ok  = wdata[15:0] <= `FSIO_TESTFLOW_MAX;

    ////////////////////////////////////////////////////////////////////
    // control input: two-stage sync then edge
    logic in_meta;
    logic in_sync;
    logic in_prev;
    wire  in_rise = in_sync & ~in_prev;                     // see (R24)
    fsio_in_fn_t in_fn;
    assign in_fn = fsio_in_fn_t'(ctrl[2:0]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_meta <= 1'b0;
            in_sync <= 1'b0;
            in_prev <= 1'b0;
        end else begin
            in_meta <= control_input_i;
            in_sync <= in_meta;
            in_prev <= in_sync;
        end
    end

    // input function decode
    wire next_clear  = in_rise & (in_fn == FSIO_IN_RESET);  // see (R15)
    wire next_offset = in_rise & (in_fn == FSIO_IN_OFFSET); // see (R16)
    wire next_creep  = in_sync & (in_fn == FSIO_IN_CREEP);  // see (R17)
    // a running dose locks the start input
    wire next_dose   = in_rise & (in_fn == FSIO_IN_DOSE)
                       & ~meas_i.dosing;                    // see (R19)

    ////////////////////////////////////////////////////////////////////
    // register writes; test start bit and value cleared by reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl       <= `FSIO_CTRL_RESET;                 // see (R14)
            out_cfg[0] <= `FSIO_OUT1_RESET;                 // see (R6)
            out_cfg[1] <= `FSIO_OUT2_RESET;                 // see (R6)
            full_scale <= FULLSCALE_DEFAULT;                // see (R2)
            test_flow  <= 16'h0000;                         // see (R21)
        end else begin
            if (wr_ctrl)
                ctrl <= wdata[4:0];
            if (wr_out1)
                out_cfg[0] <= wdata[4:0];                   // see (R5)
            if (wr_out2)
                out_cfg[1] <= wdata[4:0];                   // see (R7)
            if (wr_fs && fs_ok)
                full_scale <= wdata[19:0];                  // see (R1)
            if (wr_test && test_ok)
                test_flow <= wdata[15:0];                   // see (R20)
        end
    end

    // sticky event flags, set wins over write-one-clear
    wire [2:0] evt_set = {next_dose, next_offset, next_clear};
    always_ff @(posedge clk_i) begin
        if (rst_i)
            events <= 3'h0;
        else
            events <= (events & ~(wr_evt ? wdata[2:0] : 3'h0)) | evt_set;
    end

    ////////////////////////////////////////////////////////////////////
    // effective measurement: test flow stands in for real flow
    wire test_on  = ctrl[`FSIO_CTRL_TEST_BIT];
    wire m_empty  = meas_i.empty & ~test_on;                // see (R20)
    wire m_flow   = meas_i.flow | (test_on & (test_flow != 16'h0000));

    ////////////////////////////////////////////////////////////////////
    // per-output function, protection and drive
    fsio_drive_t drv [2];
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_out
            fsio_out_fn_t fn;
            logic sink;
            logic nc;
            logic act;
            logic hiz;
            logic [26:0] prot_cnt;
            logic tripped;
            assign fn   = fsio_out_fn_t'(out_cfg[g][2:0]);
            assign sink = out_cfg[g][`FSIO_OCFG_SINK_BIT];
            assign nc   = out_cfg[g][`FSIO_OCFG_NC_BIT];

            // active means driven, for open sense
            always_comb begin
                act = 1'b0;
                hiz = 1'b0;
                unique case (fn)
                    FSIO_FN_OFF:   hiz = 1'b1;
                    FSIO_FN_PULSE: begin                    // see (R9)
                        // sense is ignored in pulse mode
                        if (sink)
                            act = ~(m_flow & ~m_empty);
                        else
                            act = m_flow & ~m_empty & meas_i.pulse;
                    end
                    FSIO_FN_DOSE: begin                     // see (R12)
                        act = meas_i.dosing ^ nc;
                        hiz = meas_i.startup;
                    end
                    FSIO_FN_NEG:   act = meas_i.negative ^ nc;
                    FSIO_FN_LOWER:                          // see (R11)
                        act = ~meas_i.below_lower ^ nc;
                    FSIO_FN_UPPER:                          // see (R10)
                        act = ~meas_i.above_upper ^ nc;
                    FSIO_FN_EMPTY: act = m_empty ^ nc;      // see (R8)
                    default:       hiz = 1'b1;
                endcase
            end

            // overload: trip after the delay, hold off, then retry
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    prot_cnt <= 27'h0000000;
                    tripped  <= 1'b0;
                end else if (tripped) begin
                    if (prot_cnt >= 27'(PAUSE_CYC - 1)) begin
                        tripped  <= 1'b0;                   // see (R4)
                        prot_cnt <= 27'h0000000;
                    end else begin
                        prot_cnt <= prot_cnt + 27'h0000001;
                    end
                end else if (overload_i[g]) begin
                    if (prot_cnt >= 27'(TRIP_CYC - 1)) begin
                        tripped  <= 1'b1;                   // see (R4)
                        prot_cnt <= 27'h0000000;
                    end else begin
                        prot_cnt <= prot_cnt + 27'h0000001;
                    end
                end else begin
                    prot_cnt <= 27'h0000000;
                end
            end

            // enable plus polarity: source drives high, sink low
            assign drv[g].en    = act & ~hiz & ~tripped
                                  & ~undervolt_i;           // see (R3)
            assign drv[g].level = ~sink;                    // see (R23)
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_switch_output_o  <= '0;
            second_switch_output_o <= '0;
            counter_clear_o        <= 1'b0;
            offset_capture_o       <= 1'b0;
            dose_start_o           <= 1'b0;
            creep_off_o            <= 1'b0;
            filter_strong_o        <= 1'b0;
            test_active_o          <= 1'b0;
            test_flow_o            <= 16'h0000;
            full_scale_o           <= FULLSCALE_DEFAULT;
        end else begin
            first_switch_output_o  <= drv[0];
            second_switch_output_o <= drv[1];
            counter_clear_o        <= next_clear;
            offset_capture_o       <= next_offset;
            dose_start_o           <= next_dose;            // see (R19)
            creep_off_o            <= next_creep;           // see (R17)
            // pulsation overrides filters only while it lasts
            filter_strong_o        <= ctrl[`FSIO_CTRL_PUMP_BIT]
                                      & meas_i.pulsating;   // see (R22)
            test_active_o          <= test_on;
            test_flow_o            <= test_flow;
            full_scale_o           <= full_scale;           // see (R1)
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses read zero and still ack
    logic [31:0] rdata;
    always_comb begin
        unique case (wb_adr_i)
            `FSIO_REG_CTRL:      rdata = {27'h0, ctrl};
            `FSIO_REG_OUT1:      rdata = {27'h0, out_cfg[0]};
            `FSIO_REG_OUT2:      rdata = {27'h0, out_cfg[1]};
            `FSIO_REG_FULLSCALE: rdata = {12'h000, full_scale};
            `FSIO_REG_TESTFLOW:  rdata = {16'h0000, test_flow};
            `FSIO_REG_STATUS:    rdata = {26'h0, g_out[1].tripped,
                                          g_out[0].tripped,
                                          undervolt_i, meas_i.dosing,
                                          in_sync, filter_strong_o};
            `FSIO_REG_EVENTS:    rdata = {29'h0, events};
            default:             rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rdata : 32'h00000000;
        end
    end

endmodule // fsio_top
`default_nettype wire

/* File: verification/fsio_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module fsio_checker
    import fsio_pkg::*;
#(
    parameter int unsigned TRIP_CYC          = 4,
    parameter logic [19:0] FULLSCALE_DEFAULT = 20'h186A0
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        undervolt_i,
    input wire logic [1:0]  overload_i,
    input wire logic        control_input_i,
    input wire fsio_drive_t first_switch_output_o,
    input wire fsio_drive_t second_switch_output_o,
    input wire logic        counter_clear_o,
    input wire logic        creep_off_o,
    input wire logic [19:0] full_scale_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // overload run length on the first output, saturating
    logic [15:0] ovl_run;
    always_ff @(posedge clk_i) begin
        if (rst_i || !overload_i[0]) ovl_run <= 16'h0000;
        else if (ovl_run != 16'hFFFF) ovl_run <= ovl_run + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_restart; $fell(rst_i); endsequence
    property p_ack; s_req |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("request not acked");
    property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack too long");
    property p_undervolt; undervolt_i |=> !first_switch_output_o.en
        && !second_switch_output_o.en; endproperty
    a_undervolt: assert property (p_undervolt)
        else $error("output driven in undervoltage");
    // margin of two cycles covers the registered enable
    property p_trip; ovl_run > TRIP_CYC + 2 |-> !first_switch_output_o.en;
    endproperty
    a_trip: assert property (p_trip) else $error("overload not released");
    property p_clr_single; counter_clear_o |=> !counter_clear_o; endproperty
    a_clr_single: assert property (p_clr_single) else $error("clear pulse long");
    property p_clr_cause; counter_clear_o |-> $past(control_input_i, 3);
    endproperty
    a_clr_cause: assert property (p_clr_cause) else $error("clear without pin");
    property p_creep_level; $changed(creep_off_o) |->
        creep_off_o == $past(control_input_i, 3); endproperty
    a_creep_level: assert property (p_creep_level) else $error("creep level");
    property p_fs_default; s_restart |-> full_scale_o == FULLSCALE_DEFAULT;
    endproperty
    a_fs_default: assert property (p_fs_default) else $error("full scale reset");
endmodule // fsio_checker

bind fsio_top fsio_checker #(
    .TRIP_CYC(TRIP_CYC),
    .FULLSCALE_DEFAULT(FULLSCALE_DEFAULT)
) u_checker (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .undervolt_i(undervolt_i), .overload_i(overload_i),
    .control_input_i(control_input_i),
    .first_switch_output_o(first_switch_output_o),
    .second_switch_output_o(second_switch_output_o),
    .counter_clear_o(counter_clear_o), .creep_off_o(creep_off_o),
    .full_scale_o(full_scale_o)
);
`default_nettype wire

/* File: verification/fsio_load.sv */
`timescale 1ns/1ps
`default_nettype none
module fsio_load
    import fsio_pkg::*;
(
    input  wire fsio_drive_t out1_i,
    input  wire fsio_drive_t out2_i,
    input  wire logic [1:0]  short_i,
    output logic      [1:0]  overload_o,
    output logic      [1:0]  line_o
);
    // a shorted line draws excess current only while driven
    assign overload_o = short_i & {out2_i.en, out1_i.en};
    // released lines fall to the load's pull-down; closed sense on a
    // dosing valve line leaves the valve open after the batch
    assign line_o = {out2_i.en & out2_i.level, out1_i.en & out1_i.level};
endmodule // fsio_load
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsio_map.svh"
module tb;
    import fsio_pkg::*;
    localparam int unsigned TRIP  = 4;
    localparam int unsigned PAUSE = 20;
    // cfg[15:11] meas[10:2] driven[1] line[0]
    localparam logic [15:0] ROWS [21] = '{
        16'h3203, 16'h3000, 16'hB200, 16'hB003,
        16'h0913, 16'h0A00, 16'h4802, 16'h4900, 16'hC802,
        16'h2803, 16'h2820, 16'hA823,
        16'hE042, 16'hE000, 16'h6002,
        16'h100B, 16'h1408, 16'h9003, 16'h9400,
        16'h1883, 16'h0200};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, uv = 1'b0, pin = 1'b0;
    logic [3:0]  sel = 4'hF;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, q, num_errors = 32'h0, num_checks = 32'h0;
    logic        ack, clr, ofs, dst, crp, fst, tact;
    logic [1:0]  ovl, line, shrt = 2'h0;
    logic [15:0] tfl;
    logic [19:0] fs;
    fsio_meas_t  meas = '0;
    fsio_drive_t o1, o2;
    // short counts keep the overload pause well inside the run
    fsio_top #(.TRIP_CYC(TRIP), .PAUSE_CYC(PAUSE)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .meas_i(meas), .undervolt_i(uv),
        .overload_i(ovl), .control_input_i(pin),
        .first_switch_output_o(o1), .second_switch_output_o(o2),
        .counter_clear_o(clr), .offset_capture_o(ofs), .dose_start_o(dst),
        .creep_off_o(crp), .filter_strong_o(fst), .test_active_o(tact),
        .test_flow_o(tfl), .full_scale_o(fs));
    fsio_load load (.out1_i(o1), .out2_i(o2), .short_i(shrt),
        .overload_o(ovl), .line_o(line));
    always #25 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 32'h0 && num_checks > 32'h0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks = num_checks + 32'h1;
        if (s !== e) begin
            num_errors = num_errors + 32'h1;
            $display("unexpected %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    // classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk_i);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 20) begin
            chk("ack wait", 1'b0, 1'b1);
            finish_test();
        end
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask
    // bounded wait for the first output enable to reach a level
    task automatic wait_en(input logic v, input int lim, output int n);
        for (n = 0; n < lim && o1.en !== v; n++) @(posedge clk_i);
        if (n == lim) begin
            chk("enable wait", 1'b0, 1'b1);
            finish_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rchk("out1", `FSIO_REG_OUT1, 32'h1);
        rchk("out2", `FSIO_REG_OUT2, 32'h6);
        rchk("ctrl", `FSIO_REG_CTRL, 32'h0);
        rchk("fs", `FSIO_REG_FULLSCALE, 32'h186A0);
        bus(1'b1, 8'h1C, 32'hFFFFFFFF);
        rchk("unmapped", 8'h1C, 32'h0);
        bus(1'b1, `FSIO_REG_FULLSCALE, 32'hC3501);
        rchk("fs_over", `FSIO_REG_FULLSCALE, 32'h186A0);
        bus(1'b1, `FSIO_REG_FULLSCALE, 32'hC3500);
        repeat (2) @(posedge clk_i);
        chk("fs_max", fs, 32'hC3500);
        // only the low lane selected: upper lanes land as zero
        sel <= 4'h1;
        bus(1'b1, `FSIO_REG_FULLSCALE, 32'h000C3512);
        sel <= 4'hF;
        rchk("fs_sel", `FSIO_REG_FULLSCALE, 32'h12);
        $display("test registers done");
    endtask
    // second output stays on its empty-pipe default throughout
    task automatic t_outs;
        logic [15:0] r;
        for (int i = 0; i < 21; i++) begin
            r = ROWS[i];
            meas <= fsio_meas_t'(r[10:2]);
            bus(1'b1, `FSIO_REG_OUT1, {27'h0, r[15:11]});
            repeat (3) @(posedge clk_i);
            chk("en1", o1.en, r[1]);
            chk("line1", line[0], r[0]);
            chk("en2", o2.en, r[9]);
            chk("line2", line[1], r[9]);
        end
        $display("test outputs done");
    endtask
    task automatic t_faults;
        int n;
        meas <= fsio_meas_t'(9'h080);
        bus(1'b1, `FSIO_REG_OUT1, 32'h6);
        repeat (3) @(posedge clk_i);
        uv <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("undervolt", {o1.en, o2.en}, 2'b00);
        uv <= 1'b0;
        wait_en(1'b1, 10, n);
        shrt <= 2'b01;
        wait_en(1'b0, 40, n);
        chk("trip", n >= TRIP && n <= TRIP + 4, 1'b1);
        shrt <= 2'b00;
        wait_en(1'b1, 200, n);
        chk("pause", n >= PAUSE - 2 && n <= PAUSE + 4, 1'b1);
        $display("test faults done");
    endtask
    // pin high for 21 sampled edges, events counted {clr,ofs,dose,creep}
    task automatic t_pin(input logic [2:0] fn, input logic d, logic [31:0] e);
        logic [7:0] cc, co, cd, cr;
        {cc, co, cd, cr} = 32'h0;
        meas <= fsio_meas_t'({7'h0, d, 1'b0});
        bus(1'b1, `FSIO_REG_CTRL, {29'h0, fn});
        pin <= 1'b1;
        for (int i = 0; i < 30; i++) begin
            @(posedge clk_i);
            if (i == 20) pin <= 1'b0;
            cc = cc + 8'(clr);
            co = co + 8'(ofs);
            cd = cd + 8'(dst);
            cr = cr + 8'(crp);
        end
        chk("pin events", {cc, co, cd, cr}, e);
    endtask
    task automatic t_test;
        meas <= fsio_meas_t'(9'h080);
        bus(1'b1, `FSIO_REG_TESTFLOW, 32'h7D01);
        rchk("tf_over", `FSIO_REG_TESTFLOW, 32'h0);
        bus(1'b1, `FSIO_REG_TESTFLOW, 32'h7D00);
        bus(1'b1, `FSIO_REG_CTRL, 32'h10);
        repeat (3) @(posedge clk_i);
        chk("test on", {tact, o1.en, tfl}, {2'b10, 16'h7D00});
        meas <= fsio_meas_t'(9'h001);
        bus(1'b1, `FSIO_REG_CTRL, 32'h18);
        repeat (3) @(posedge clk_i);
        chk("strong", fst, 1'b1);
        meas <= '0;
        repeat (3) @(posedge clk_i);
        chk("weak", fst, 1'b0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("restart", {tact, tfl}, 17'h0);
        rchk("tf_clear", `FSIO_REG_TESTFLOW, 32'h0);
        $display("test flow simulation done");
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_outs();
        t_faults();
        t_pin(3'h0, 1'b0, 32'h0);
        t_pin(3'h1, 1'b0, 32'h01000000);
        t_pin(3'h4, 1'b0, 32'h00010000);
        t_pin(3'h2, 1'b0, 32'h00000100);
        t_pin(3'h2, 1'b1, 32'h0);
        t_pin(3'h3, 1'b0, 32'h15);
        // sticky flags from the clear, offset and dose runs above
        rchk("events", `FSIO_REG_EVENTS, 32'h7);
        bus(1'b1, `FSIO_REG_EVENTS, 32'h7);
        rchk("evt_clr", `FSIO_REG_EVENTS, 32'h0);
        $display("test control input done");
        t_test();
        finish_test();
    end
endmodule // tb
`default_nettype wire
